// *** hdl/rss_pkg.sv ***
/*
 Package for the reset source sequencer: timing counts, vector addresses
 and the sequencer state type.
 Assumes a 40 MHz system clock and an E-clock enable from a divider.
*/
package rss_pkg;
   // E-clock: one enable pulse every E_DIV system clocks
   localparam int E_DIV = 4;
   // Stabilisation delay after power-on, in internal cycles
   localparam int POR_CYCLES = 4064;
   // Pin drive time and sample delay, in E-clock cycles
   localparam int PIN_DRIVE_CYCLES = 4;
   localparam int PIN_SAMPLE_CYCLES = 2;
   // Reset vector addresses
   localparam logic [15:0] VEC_NORMAL = 16'hFFFE;
   localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
   localparam logic [15:0] VEC_WDOG = 16'hFFFA;
   localparam logic [15:0] VEC_SPECIAL_NORMAL = 16'hBFFE;
   localparam logic [15:0] VEC_SPECIAL_CLKMON = 16'hBFFC;
   localparam logic [15:0] VEC_SPECIAL_WDOG = 16'hBFFA;
   // Sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_RUN = 5'b0_0001,
      ST_POR = 5'b0_0010,
      ST_DRIVE = 5'b0_0100,
      ST_SAMPLE = 5'b0_1000,
      ST_FETCH = 5'b1_0000
   } rss_state_t;
endpackage

// *** hdl/rss_ediv.sv ***
/*
 E-clock enable divider: one-cycle pulse every DIV clocks.
 Assumes a single system clock and synchronous active-low reset.
*/
module rss_ediv #(
   parameter int DIV = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   output logic e_en
);
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic e_reg;
   logic e_next;

   initial begin
      if (DIV < 1 || DIV > 255) begin
         $error("DIV out of range");
      end
   end

   // Wrap counter and pulse at the wrap
   always_comb begin
      if (cnt_reg == 8'(DIV - 1)) begin
         cnt_next = 8'h00;
         e_next = 1'b1;
      end else begin
         cnt_next = cnt_reg + 8'h01;
         e_next = 1'b0;
      end
   end

   // Register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_reg <= 8'h00;
         e_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         e_reg <= e_next;
      end
   end

   assign e_en = e_reg;
endmodule

// *** hdl/rss_seq.sv ***
/*
 Reset source sequencer: gathers power-on, pin, watchdog and clock-monitor
 resets, holds the core, drives the reset pin and picks the vector.
 Assumes synchronous inputs, a 40 MHz clock, and an external pin pull-up
 that raises the released pin within two E-clock cycles.
*/
// Behaviour
// RULE_01: Four sources each start a reset
// RULE_02: Power-on and pin share one vector
// RULE_03: Reset aborts core and forces start vector
// RULE_04: Power-on only from supply rise
// RULE_05: Hold core 4064 cycles after power-on
// RULE_06: Stay in reset while pin low
// RULE_07: Drive pin low four E cycles
// RULE_08: Sample two cycles later; low means external
// RULE_09: High sample means internal cause vector
// RULE_10: Outside circuit raises pin within two cycles
// RULE_11: Power-on path only on cold start
// RULE_12: Vectors FFFE, FFFC, FFFA; special alternates
// RULE_13: Latch cause until vector fetch done
module rss_seq
   import rss_pkg::*;
#(
   parameter int POR_COUNT = rss_pkg::POR_CYCLES
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic POWER_UP,
   input wire logic PIN_IN,
   input wire logic WDOG_TIMEOUT,
   input wire logic CLKMON_FAIL,
   input wire logic SPECIAL_MODE,
   input wire logic FETCH_DONE,
   output logic PIN_OUT,
   output logic PIN_OE,
   output logic CORE_RESET,
   output logic [15:0] VECTOR,
   output logic EXT_CAUSE
);
   import rss_pkg::*;

   initial begin
      if (POR_COUNT < 1 || POR_COUNT > 65535) begin
         $error("POR_COUNT out of range");
      end
   end

   logic e_en;
   rss_state_t st_reg, st_next;
   logic [15:0] cnt_reg, cnt_next;
   logic wd_reg, wd_next;
   logic cm_reg, cm_next;
   logic ext_reg, ext_next;
   logic oe_reg, oe_next;
   logic core_reg, core_next;
   logic [15:0] vec_reg, vec_next;
   logic pwr_seen_reg, pwr_seen_next;
   logic [4:0] drv_cyc_reg, drv_cyc_next;

   // Vector lookup by cause and mode
   function automatic logic [15:0] pick_vec(input logic wd, input logic cm,
                                            input logic sp);
      logic [15:0] v;
      v = sp ? VEC_SPECIAL_NORMAL : VEC_NORMAL;
      if (cm) begin
         v = sp ? VEC_SPECIAL_CLKMON : VEC_CLKMON;
      end else if (wd) begin
         v = sp ? VEC_SPECIAL_WDOG : VEC_WDOG;
      end
      return v;
   endfunction

   rss_ediv #(.DIV(E_DIV)) rss_ediv_i (
      .clk(CLK),
      .rst_n(RST_N),
      .e_en(e_en)
   );

   // Sequencer next-state logic
   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      wd_next = wd_reg;
      cm_next = cm_reg;
      ext_next = ext_reg;
      oe_next = oe_reg;
      core_next = core_reg;
      vec_next = vec_reg;
      pwr_seen_next = pwr_seen_reg | POWER_UP;
      // Supply rise: cold start only, never a brownout detector
      if (POWER_UP && !pwr_seen_reg) begin // RULE_04 RULE_11
         st_next = ST_POR;
         cnt_next = 16'h0000;
         core_next = 1'b1; // RULE_03
         oe_next = 1'b0;
         wd_next = 1'b0;
         cm_next = 1'b0;
      end else begin
         unique case (st_reg)
            ST_RUN: begin
               // Any source starts a reset
               if (WDOG_TIMEOUT || CLKMON_FAIL || !PIN_IN) begin // RULE_01
                  st_next = ST_DRIVE;
                  core_next = 1'b1; // RULE_03
                  oe_next = 1'b1; // RULE_07
                  cnt_next = 16'h0000;
                  cm_next = CLKMON_FAIL;
                  wd_next = WDOG_TIMEOUT;
               end
            end
            ST_POR: begin
               // Stabilisation count, then wait for pin high
               if (cnt_reg < 16'(POR_COUNT)) begin // RULE_05
                  // Hold is counted in internal E cycles
                  if (e_en) begin
                     cnt_next = cnt_reg + 16'h0001;
                  end
               end else if (PIN_IN) begin // RULE_06
                  ext_next = 1'b1;
                  vec_next = pick_vec(1'b0, 1'b0, SPECIAL_MODE); // RULE_02
                  st_next = ST_FETCH;
               end
            end
            ST_DRIVE: begin
               if (e_en) begin
                  if (cnt_reg == 16'(PIN_DRIVE_CYCLES - 1)) begin // RULE_07
                     oe_next = 1'b0;
                     cnt_next = 16'h0000;
                     st_next = ST_SAMPLE;
                  end else begin
                     cnt_next = cnt_reg + 16'h0001;
                  end
               end
            end
            ST_SAMPLE: begin
               if (e_en) begin
                  if (cnt_reg == 16'(PIN_SAMPLE_CYCLES - 1)) begin // RULE_08
                     // Low pin means outside reset; high means own cause
                     ext_next = !PIN_IN; // RULE_08 RULE_10
                     vec_next = pick_vec(wd_reg && PIN_IN,
                                         cm_reg && PIN_IN,
                                         SPECIAL_MODE); // RULE_09 RULE_12
                     st_next = ST_FETCH;
                  end else begin
                     cnt_next = cnt_reg + 16'h0001;
                  end
               end
            end
            ST_FETCH: begin
               // Cause and vector held until the fetch completes
               if (FETCH_DONE && PIN_IN) begin // RULE_13 RULE_06
                  core_next = 1'b0;
                  st_next = ST_RUN;
               end
            end
            default: begin
               st_next = ST_RUN;
            end
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         st_reg <= ST_RUN;
         cnt_reg <= 16'h0000;
         wd_reg <= 1'b0;
         cm_reg <= 1'b0;
         ext_reg <= 1'b0;
         oe_reg <= 1'b0;
         core_reg <= 1'b1;
         vec_reg <= VEC_NORMAL;
         pwr_seen_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         wd_reg <= wd_next;
         cm_reg <= cm_next;
         ext_reg <= ext_next;
         oe_reg <= oe_next;
         core_reg <= core_next;
         vec_reg <= vec_next;
         pwr_seen_reg <= pwr_seen_next;
      end
   end

   // Length of the current pin drive, watched by the drive checks
   always_comb begin
      drv_cyc_next = 5'h00;
      if (oe_reg) begin
         drv_cyc_next = drv_cyc_reg + 5'h01;
      end
   end

   // Drive length register
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         drv_cyc_reg <= 5'h00;
      end else begin
         drv_cyc_reg <= drv_cyc_next;
      end
   end

   assign PIN_OUT = 1'b0;
   assign PIN_OE = oe_reg;
   assign CORE_RESET = core_reg;
   assign VECTOR = vec_reg;
   assign EXT_CAUSE = ext_reg;

   // Checks
   src_starts_a: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_01
      st_reg == ST_RUN && !(POWER_UP && !pwr_seen_reg)
      && (WDOG_TIMEOUT || CLKMON_FAIL)
      |=> st_reg == ST_DRIVE && core_reg && oe_reg)
      else $error("source did not start reset");
   core_held_a: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_03
      st_reg != ST_RUN |-> core_reg)
      else $error("core not held in reset");
   por_hold_a: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_05
      st_reg == ST_POR && cnt_reg < 16'(POR_COUNT) |=> st_reg == ST_POR)
      else $error("left power-on hold early");
   pin_wait_a: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_06
      st_reg == ST_POR && !PIN_IN |=> st_reg == ST_POR)
      else $error("left reset while pin low");
   drive_len_a: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_07
      $fell(oe_reg) && st_reg == ST_SAMPLE
      |-> drv_cyc_reg >= 5'h0D && drv_cyc_reg <= 5'h10)
      else $error("pin drive length wrong");
   drive_max_a: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_07
      oe_reg |-> drv_cyc_reg < 5'h10)
      else $error("pin driven too long");
   ext_class_a: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_08
      st_reg == ST_SAMPLE && st_next == ST_FETCH && !PIN_IN |=> ext_reg)
      else $error("external reset not flagged");
   int_vec_a: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_09
      st_reg == ST_SAMPLE && st_next == ST_FETCH && PIN_IN && wd_reg
      && !cm_reg && !SPECIAL_MODE |=> vec_reg == VEC_WDOG)
      else $error("watchdog vector wrong");
   vec_hold_a: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_13
      st_reg == ST_FETCH && pwr_seen_reg |=> $stable(vec_reg))
      else $error("vector changed during fetch");
   cold_only_a: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_11
      pwr_seen_reg && st_reg == ST_RUN && PIN_IN
      && !WDOG_TIMEOUT && !CLKMON_FAIL |=> st_reg == ST_RUN)
      else $error("spurious reset");
   cov_por_c: cover property (@(posedge CLK) st_reg == ST_POR ##1
      st_reg == ST_FETCH);
   cov_wd_c: cover property (@(posedge CLK) st_reg == ST_SAMPLE && wd_reg
      ##1 st_reg == ST_FETCH);
   cov_ext_c: cover property (@(posedge CLK) $rose(ext_reg));
endmodule

// *** verification/rss_pin_model.sv ***
/*
 External reset circuit on the reset pin: pull-up plus an open-drain
 hold under bench command.
 Assumes the device drives the pin only while pin_oe is high.
*/
module rss_pin_model (
   input wire logic pin_out,
   input wire logic pin_oe,
   input wire logic hold_low,
   output logic pin_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // Wired pin; the pull-up restores high at once on release
   assign pin_level = pin_oe ? pin_out : !hold_low;
endmodule

// *** verification/rss_seq_tb_top.sv ***
/*
 Self-checking bench for the reset source sequencer.
 Assumes a 40 MHz clock, POR_COUNT shortened to 16, E enable every 4.
*/
module rss_seq_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rss_pkg::*;
   logic clk = 0, rst_n = 0, power_up = 0, wdog = 0, clkmon = 0;
   logic special = 0, fetch_done = 0, hold_low = 0;
   logic pin_in, pin_out, pin_oe, core_reset, ext_cause;
   logic [15:0] vector;
   int err_total = 0, checked = 0, cycles = 0;
   rss_seq #(.POR_COUNT(16)) rss_seq_i (.CLK(clk), .RST_N(rst_n),
      .POWER_UP(power_up), .PIN_IN(pin_in), .WDOG_TIMEOUT(wdog),
      .CLKMON_FAIL(clkmon), .SPECIAL_MODE(special),
      .FETCH_DONE(fetch_done), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
      .CORE_RESET(core_reset), .VECTOR(vector), .EXT_CAUSE(ext_cause));
   rss_pin_model rss_pin_model_i (.pin_out(pin_out), .pin_oe(pin_oe),
      .hold_low(hold_low), .pin_level(pin_in));
   // Clock and hang guard
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         err_total++;
         wrap_up();
      end
   end
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Core finishes its vector fetch; reset must drop next edge
   task automatic finish_fetch();
      @(posedge clk) fetch_done <= 1;
      @(posedge clk) fetch_done <= 0;
      #1 check("core_reset", core_reset, 0);
   endtask
   // Cold start with pin held low past the stabilisation count
   task automatic power_on();
      @(posedge clk) begin
         hold_low <= 1;
         power_up <= 1;
      end
      repeat (80) @(posedge clk);
      #1 check("core_reset", core_reset, 1);
      finish_fetch_blocked();
      @(posedge clk) hold_low <= 0;
      repeat (16) @(posedge clk);
      #1 check("vector", vector, VEC_NORMAL);
      check("ext_cause", ext_cause, 1);
      finish_fetch();
   endtask
   // A fetch while the pin is low must not end the reset
   task automatic finish_fetch_blocked();
      @(posedge clk) fetch_done <= 1;
      @(posedge clk) fetch_done <= 0;
      repeat (2) @(posedge clk);
      #1 check("core_reset", core_reset, 1);
   endtask
   // One reset from an internal source or from the pin
   task automatic run_src(logic wd, logic cm, logic ext, logic sp,
                          logic [15:0] exp_v);
      int n;
      n = 1; // The cycle before the first check is already driven
      @(posedge clk) begin
         special <= sp;
         wdog <= wd;
         clkmon <= cm;
         hold_low <= ext;
      end
      @(posedge clk) begin
         wdog <= 0;
         clkmon <= 0;
      end
      @(posedge clk);
      #1 check("pin_oe", pin_oe, 1);
      check("core_reset", core_reset, 1);
      while (pin_oe === 1 && n < 20) begin
         @(posedge clk);
         #1 n++;
      end
      check("drive_len_ok", 16'(n >= 13 && n <= 16), 1);
      repeat (12) @(posedge clk);
      #1 check("vector", vector, exp_v);
      check("ext_cause", ext_cause, 16'(ext));
      @(posedge clk) special <= ~sp;
      @(posedge clk);
      #1 check("vector_held", vector, exp_v);
      @(posedge clk) hold_low <= 0;
      finish_fetch();
   endtask
   // Later supply rises must not start the power-on path
   task automatic warm_rise();
      @(posedge clk) power_up <= 0;
      repeat (3) @(posedge clk);
      @(posedge clk) power_up <= 1;
      repeat (30) @(posedge clk);
      #1 check("core_reset", core_reset, 0);
      check("pin_oe", pin_oe, 0);
   endtask
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1;
      power_on();
      run_src(1, 0, 0, 0, VEC_WDOG);
      run_src(0, 1, 0, 0, VEC_CLKMON);
      run_src(1, 1, 0, 0, VEC_CLKMON);
      run_src(1, 0, 0, 1, VEC_SPECIAL_WDOG);
      run_src(0, 1, 0, 1, VEC_SPECIAL_CLKMON);
      run_src(0, 0, 1, 0, VEC_NORMAL);
      run_src(0, 0, 1, 1, VEC_SPECIAL_NORMAL);
      warm_rise();
      wrap_up();
   end
endmodule
